// ===== common/cpd_pkg.sv
// ==========================================================================
// Clock power-down control: shared constants
// ==========================================================================
package cpd_pkg;

  // ========================================================================
  // Bus and register map
  // ========================================================================
  localparam int unsigned CPD_ADDR_W = 8;              // APB address width
  localparam logic [7:0] CPD_REG_DRIVE_MODE = 8'h00;   // Park drive-mode bits
  localparam logic [7:0] CPD_REG_STATUS = 8'h04;       // Read-only state view
  localparam int unsigned CPD_NUM_PAIRS = 4;           // SRC group + three CPU pairs
  localparam logic [3:0] CPD_DRIVE_MODE_RST = 4'h0;    // All pairs driven when parked

  // Status field positions
  localparam int unsigned CPD_ST_PD_MODE = 0;          // Shared pin now means power-down
  localparam int unsigned CPD_ST_REQ = 1;              // Synchronised request level
  localparam int unsigned CPD_ST_SE_RUN = 2;           // Single-ended outputs running
  localparam int unsigned CPD_ST_OSC_ON = 3;           // Crystal oscillator enabled
  localparam int unsigned CPD_ST_STABLE = 4;           // Clocks stable and enabled
  localparam int unsigned CPD_ST_LATE = 5;             // Power-up latency exceeded
  localparam int unsigned CPD_ST_STATE = 6;            // Three-bit sequencer state

  // ========================================================================
  // Timing
  // ========================================================================
  localparam int unsigned CPD_CLK_PERIOD_NS = 4;       // clk_sys at 250 MHz
  localparam int unsigned CPD_T_POWER_UP_NS = 1800000; // 1.8 ms power-up latency
  localparam int unsigned CPD_POWER_UP_CYC = CPD_T_POWER_UP_NS / CPD_CLK_PERIOD_NS;
  localparam int unsigned CPD_T_DRIVE_HIGH_NS = 300000; // 300 us to drive true legs high
  localparam int unsigned CPD_DRIVE_HIGH_CYC = CPD_T_DRIVE_HIGH_NS / CPD_CLK_PERIOD_NS;
  localparam int unsigned CPD_WAKE_CNT_W = 20;         // Holds the 1.8 ms count
  localparam int unsigned CPD_QUAL_EDGES = 2;          // Rising edges to qualify a request
  localparam int unsigned CPD_PARK_PERIODS = 4;        // Latest park, in output periods

  // ========================================================================
  // Sequencer states
  // ========================================================================
  typedef enum logic [2:0] {
    CPD_ST_INIT    = 3'b000,  // Pin still acts as supply-good
    CPD_ST_RUN     = 3'b001,  // Clocks running, watching for a request
    CPD_ST_STOP_SE = 3'b010,  // Waiting for falling edge to stop single-ended
    CPD_ST_PARK    = 3'b011,  // Waiting for falling edge to park differential
    CPD_ST_OSC_OFF = 3'b100,  // Outputs held, shutting VCOs and crystal
    CPD_ST_DOWN    = 3'b101,  // Powered down
    CPD_ST_WAKE    = 3'b110   // Oscillators restarting, waiting for lock
  } cpd_state_e;

endpackage

// ===== logic/cpd_sync.sv
`timescale 1ns/1ps
// ==========================================================================
// Two-flop synchroniser for the asynchronous shared pin
// ==========================================================================
module cpd_sync #(
  parameter logic RST_VAL = 1'b0  // Level shown during and after reset
) (
  input wire logic clk_sys,   // System clock
  input wire logic rst,       // Asynchronous reset, active high
  input wire logic async_in,  // Asynchronous level
  output logic sync_out       // Level in the clk_sys domain
);

  logic meta_q;  // First stage, read by the second stage only

  // Two stages; the first may go metastable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ===== logic/cpd_power_ctrl.sv
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module cpd_power_ctrl
  import cpd_pkg::*;
#(
  parameter int unsigned NUM_PAIRS = CPD_NUM_PAIRS,             // Differential pairs
  parameter int unsigned POWER_UP_CYC = CPD_POWER_UP_CYC,       // Power-up latency in cycles
  parameter int unsigned DRIVE_HIGH_CYC = CPD_DRIVE_HIGH_CYC    // Drive-high limit in cycles
) (
  input wire logic clk_sys,                          // 250 MHz system clock
  input wire logic rst,                              // Asynchronous reset, active high
  input wire logic shared_pwr_pin,                   // Supply-good then power-down pin
  input wire logic cpu_clock_complement,             // CPU complement clock as seen here
  input wire logic pll_lock,                         // PLL locked indication
  input wire logic psel,                             // APB select
  input wire logic penable,                          // APB enable
  input wire logic pwrite,                           // APB write
  input wire logic [CPD_ADDR_W-1:0] paddr,           // APB byte address
  input wire logic [31:0] pwdata,                    // APB write data
  output logic [31:0] prdata,                        // APB read data
  output logic pready,                               // APB ready
  output logic pslverr,                              // APB error on unmapped address
  output logic se_clk_en,                            // Single-ended outputs running
  output logic [NUM_PAIRS-1:0] diff_clk_en,          // Differential pair toggling
  output logic [NUM_PAIRS-1:0] diff_true_high,       // True leg parked high at 2x Iref
  output logic [NUM_PAIRS-1:0] diff_true_oe_n,       // True leg enable, low drives
  output logic [NUM_PAIRS-1:0] diff_comp_oe_n,       // Complement leg enable, low drives
  output logic vco_en,                               // VCOs powered
  output logic osc_en,                               // Crystal oscillator powered
  output logic clk_stable                            // Stable clocks delivered
);

  // ========================================================================
  // Declarations
  // ========================================================================
  cpd_state_e state_q;                          // Sequencer state
  logic pin_sync;                               // Synchronised shared pin
  logic pd_mode_q;                              // Pin now carries power-down
  logic req_sync;                               // Synchronised request level, gated by pd_mode_q
  logic comp_q;                                 // Previous complement sample
  logic comp_rise;                              // Complement rising edge
  logic comp_fall;                              // Complement falling edge
  logic [1:0] qual_cnt_q;                       // Rising edges seen with request high
  logic [CPD_WAKE_CNT_W-1:0] wake_cnt_q;        // Cycles since wake began
  logic late_q;                                 // Latency limit passed before lock
  logic [NUM_PAIRS-1:0] drive_mode_q;           // Park mode per pair, 1 = high-Z
  logic [NUM_PAIRS-1:0] park_mode_q;            // Mode latched at the park edge
  logic park_now;                               // Park all pairs this cycle
  logic wake_drive;                             // Drive true legs high this cycle
  logic enable_all;                             // Start every output this cycle
  logic [2:0] park_falls_q;                     // Complement falls while parking
  logic [31:0] status_w;                        // Status word

  // One clock domain, so every check below shares these
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // Park levels as {true_high, true_oe_n, comp_oe_n}
  function automatic logic [2:0] park_levels(input logic hiz);
    park_levels = hiz ? 3'b011 : 3'b101;
  endfunction

  // ========================================================================
  // Shared pin and complement clock sampling
  // ========================================================================
  // The pin resets high so an idle supply-good does not look asserted
  cpd_sync #(
    .RST_VAL(1'b1)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in(shared_pwr_pin),
    .sync_out(pin_sync)
  );

  // Request only exists once the pin has changed role
  assign req_sync = pd_mode_q & pin_sync;

  // Role flag: set once, never cleared short of reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pd_mode_q <= 1'b0;
    end else if (state_q == CPD_ST_INIT && !pin_sync) begin
      pd_mode_q <= 1'b1;
    end
  end

  // Edge detect on the complement clock. Only edges matter, never a
  // frequency, so the same sequence holds at every CPU rate; the limit is
  // that the clock must be slow enough here to be sampled at all.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      comp_q <= 1'b0;
    end else begin
      comp_q <= cpu_clock_complement;
    end
  end
  assign comp_rise = cpu_clock_complement & ~comp_q;
  assign comp_fall = ~cpu_clock_complement & comp_q;

  // ========================================================================
  // Sequencer
  // ========================================================================
  assign park_now = (state_q == CPD_ST_PARK && comp_fall) || (state_q == CPD_ST_WAKE && req_sync);
  assign wake_drive = state_q == CPD_ST_DOWN && !req_sync;
  assign enable_all = state_q == CPD_ST_WAKE && !req_sync && pll_lock;

  // Main power-down and power-up walk
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= CPD_ST_INIT;
    end else begin
      case (state_q)
        CPD_ST_INIT: begin
          // Pin read only as supply-good here
          if (!pin_sync) begin
            state_q <= CPD_ST_WAKE;
          end
        end
        CPD_ST_RUN: begin
          if (comp_rise && req_sync && qual_cnt_q == 2'(CPD_QUAL_EDGES - 1)) begin
            state_q <= CPD_ST_STOP_SE;
          end
        end
        CPD_ST_STOP_SE: begin
          if (comp_fall) begin
            state_q <= CPD_ST_PARK;
          end
        end
        CPD_ST_PARK: begin
          if (comp_fall) begin
            state_q <= CPD_ST_OSC_OFF;
          end
        end
        CPD_ST_OSC_OFF: begin
          state_q <= CPD_ST_DOWN;
        end
        CPD_ST_DOWN: begin
          if (!req_sync) begin
            state_q <= CPD_ST_WAKE;
          end
        end
        CPD_ST_WAKE: begin
          // A fresh request during restart goes straight back down;
          // outputs are still parked so no clean stop is needed
          if (req_sync) begin
            state_q <= CPD_ST_OSC_OFF;
          end else if (pll_lock) begin
            state_q <= CPD_ST_RUN;
          end
        end
        default: begin
          state_q <= CPD_ST_INIT;
        end
      endcase
    end
  end

  // Qualification count of rising edges with the request high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      qual_cnt_q <= 2'h0;
    end else if (state_q != CPD_ST_RUN || !req_sync) begin
      qual_cnt_q <= 2'h0;
    end else if (comp_rise && qual_cnt_q != 2'(CPD_QUAL_EDGES)) begin
      qual_cnt_q <= qual_cnt_q + 2'h1;
    end
  end

  // Single-ended outputs stop low on the next falling edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      se_clk_en <= 1'b0;
    end else if (state_q == CPD_ST_STOP_SE && comp_fall) begin
      se_clk_en <= 1'b0;
    end else if (enable_all) begin
      se_clk_en <= 1'b1;
    end
  end

  // Oscillators go off only after every output is held
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vco_en <= 1'b1;
      osc_en <= 1'b1;
    end else if (state_q == CPD_ST_OSC_OFF) begin
      vco_en <= 1'b0;
      osc_en <= 1'b0;
    end else if (wake_drive) begin
      vco_en <= 1'b1;
      osc_en <= 1'b1;
    end
  end

  // Power-up latency timer; counts from reset for the supply ramp too
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wake_cnt_q <= '0;
      late_q <= 1'b0;
    end else if (wake_drive) begin
      wake_cnt_q <= '0;
      late_q <= 1'b0;
    end else if (state_q == CPD_ST_INIT || state_q == CPD_ST_WAKE) begin
      if (wake_cnt_q < CPD_WAKE_CNT_W'(POWER_UP_CYC)) begin
        wake_cnt_q <= wake_cnt_q + 1'b1;
      end else begin
        late_q <= 1'b1;
      end
    end
  end

  // Stable flag follows the run state
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clk_stable <= 1'b0;
    end else begin
      clk_stable <= enable_all || (state_q == CPD_ST_RUN && !(comp_rise && req_sync &&
                    qual_cnt_q == 2'(CPD_QUAL_EDGES - 1)));
    end
  end

  // ========================================================================
  // Differential pairs
  // ========================================================================
  // Each pair parks by its own mode bit; all move on the same edge
  for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        diff_clk_en[i] <= 1'b0;
        diff_true_high[i] <= 1'b0;
        diff_true_oe_n[i] <= 1'b1;
        diff_comp_oe_n[i] <= 1'b1;
        park_mode_q[i] <= 1'b1;
      end else if (park_now) begin
        diff_clk_en[i] <= 1'b0;
        {diff_true_high[i], diff_true_oe_n[i], diff_comp_oe_n[i]} <= park_levels(drive_mode_q[i]);
        park_mode_q[i] <= drive_mode_q[i];
      end else if (wake_drive) begin
        // Tri-stated pairs go high at once, well inside the limit
        {diff_true_high[i], diff_true_oe_n[i], diff_comp_oe_n[i]} <= park_levels(1'b0);
      end else if (enable_all) begin
        diff_clk_en[i] <= 1'b1;
        diff_true_high[i] <= 1'b0;
        diff_true_oe_n[i] <= 1'b0;
        diff_comp_oe_n[i] <= 1'b0;
      end
    end

    // Parked pair matches the mode captured at the park edge
    chk_park_drive_mode: assert property (state_q == CPD_ST_DOWN |->
      diff_true_high[i] == !park_mode_q[i] && diff_true_oe_n[i] == park_mode_q[i] &&
      diff_comp_oe_n[i] && !diff_clk_en[i])
      else $error("parked pair levels disagree with drive mode");

    // Leaving power-down drives the true leg high next cycle
    chk_wake_true_high: assert property (state_q == CPD_ST_DOWN && !req_sync |=>
      diff_true_high[i] && !diff_true_oe_n[i] && diff_comp_oe_n[i])
      else $error("true leg not driven high after request removal");
  end

  // ========================================================================
  // APB slave
  // ========================================================================
  // Status packs the sequencer view for software
  assign status_w = {23'h0, state_q, late_q, clk_stable, osc_en, se_clk_en, req_sync, pd_mode_q};

  // One wait state: ready rises in the second access cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      pslverr <= paddr != CPD_REG_DRIVE_MODE && paddr != CPD_REG_STATUS;
      if (!pwrite && paddr == CPD_REG_DRIVE_MODE) begin
        prdata <= {{(32 - NUM_PAIRS){1'b0}}, drive_mode_q};
      end else if (!pwrite && paddr == CPD_REG_STATUS) begin
        prdata <= status_w;
      end else begin
        prdata <= 32'h0;  // Unmapped and writes read as zero
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Drive-mode bits: bit 0 SRC group, bits above the CPU pairs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_mode_q <= NUM_PAIRS'(CPD_DRIVE_MODE_RST);
    end else if (psel && penable && pready && pwrite && paddr == CPD_REG_DRIVE_MODE) begin
      drive_mode_q <= pwdata[NUM_PAIRS-1:0];
    end
  end

  // ========================================================================
  // Checks
  // ========================================================================
  // Helper: complement falls seen since the request qualified
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      park_falls_q <= 3'h0;
    end else if ((state_q == CPD_ST_STOP_SE || state_q == CPD_ST_PARK) && comp_fall) begin
      park_falls_q <= park_falls_q + 3'h1;
    end else if (state_q != CPD_ST_STOP_SE && state_q != CPD_ST_PARK) begin
      park_falls_q <= 3'h0;
    end
  end

  chk_init_pin_role: assert property (state_q == CPD_ST_INIT && pin_sync |=>
    state_q == CPD_ST_INIT && !pd_mode_q)
    else $error("pin left supply-good role while high");

  chk_mode_sticky: assert property (pd_mode_q |=> pd_mode_q)
    else $error("power-down role was lost");

  chk_req_needs_role: assert property (!pd_mode_q |-> !req_sync && se_clk_en == 1'b0)
    else $error("request seen before pin changed role");

  chk_two_edge_qual: assert property (state_q == CPD_ST_RUN && comp_rise && req_sync &&
    qual_cnt_q == 2'h1 |=> state_q == CPD_ST_STOP_SE)
    else $error("two qualifying edges did not start the stop");

  chk_qual_restart: assert property (state_q == CPD_ST_RUN && !req_sync |=>
    qual_cnt_q == 2'h0 && state_q != CPD_ST_STOP_SE)
    else $error("qualification not restarted by low request");

  chk_se_stop_edge: assert property (state_q == CPD_ST_STOP_SE && comp_fall |=>
    !se_clk_en && state_q == CPD_ST_PARK)
    else $error("single-ended outputs not stopped on falling edge");

  chk_park_bound: assert property ((state_q == CPD_ST_STOP_SE || state_q == CPD_ST_PARK) |->
    park_falls_q < 3'(CPD_PARK_PERIODS))
    else $error("differential park later than four periods");

  chk_osc_after_stop: assert property ($fell(osc_en) |->
    !se_clk_en && diff_clk_en == '0 && $past(state_q) == CPD_ST_OSC_OFF)
    else $error("oscillator stopped before outputs were held");

  chk_enable_together: assert property ($rose(se_clk_en) |->
    &diff_clk_en && clk_stable && state_q == CPD_ST_RUN)
    else $error("outputs not enabled together");

  chk_wake_latency: assert property (state_q == CPD_ST_WAKE &&
    wake_cnt_q >= CPD_WAKE_CNT_W'(POWER_UP_CYC) && !pll_lock |=> late_q)
    else $error("power-up latency overrun not flagged");

endmodule

// ===== verif/cpd_pm_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Power-management partner: shared pin and complement clock
// ==========================================================================
module cpd_pm_model (
  input wire logic clk_sys,              // System clock
  input wire logic rst,                  // Reset, active high
  input wire logic supply_ok,            // Supply has become good
  input wire logic req,                  // Power-down wanted
  input wire logic [3:0] half,           // Complement half period, clk_sys cycles
  output logic shared_pwr_pin,           // Not-good high, then request high
  output logic cpu_clock_complement      // Complement CPU clock
);
  logic [3:0] cnt_q;  // Half-period counter

  // Pin reads not-good until supply is up, then carries the request level
  assign shared_pwr_pin = ~supply_ok | req;
  // Request raised only long after supply-good, so power-on state is run

  // Free-running complement clock, kept slower than clk_sys/2
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      cpu_clock_complement <= 1'b1;
    end else if (cnt_q + 4'h1 >= half) begin
      cnt_q <= 4'h0;
      cpu_clock_complement <= ~cpu_clock_complement;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// ===== verif/clock_power_down_control_bench.sv
`timescale 1ns/1ps
// ==========================================================================
// Bench: power-down sequencing against an integer model
// ==========================================================================
module clock_power_down_control_bench;
  import cpd_pkg::*;
  logic clk_sys, rst, pll_lock, psel, penable, pwrite, pslverr, pready, se_clk_en;
  logic vco_en, osc_en, clk_stable, shared_pwr_pin, cpu_clock_complement;
  logic supply_ok, req;                  // Partner commands
  logic [3:0] half;                      // Complement half period
  logic [7:0] paddr;                     // APB address
  logic [31:0] pwdata, prdata, rd;       // APB data
  logic err;                             // Captured slave error
  logic [3:0] diff_clk_en, diff_true_high, diff_true_oe_n, diff_comp_oe_n;
  int num_errors = 0;                    // Mismatches
  int check_count = 0;                   // Comparisons
  int seed = 32'h5f8b;                   // Random seed
  int n;                                 // Wait counter
  int m;                                 // Modelled drive-mode bits

  cpd_power_ctrl #(.POWER_UP_CYC(50), .DRIVE_HIGH_CYC(20)) u_cpd_power_ctrl (
    .clk_sys(clk_sys), .rst(rst), .shared_pwr_pin(shared_pwr_pin),
    .cpu_clock_complement(cpu_clock_complement), .pll_lock(pll_lock), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .se_clk_en(se_clk_en), .diff_clk_en(diff_clk_en),
    .diff_true_high(diff_true_high), .diff_true_oe_n(diff_true_oe_n),
    .diff_comp_oe_n(diff_comp_oe_n), .vco_en(vco_en), .osc_en(osc_en), .clk_stable(clk_stable));
  cpd_pm_model u_cpd_pm_model (
    .clk_sys(clk_sys), .rst(rst), .supply_ok(supply_ok), .req(req), .half(half),
    .shared_pwr_pin(shared_pwr_pin), .cpu_clock_complement(cpu_clock_complement));

  // ========================================================================
  // Clock and watchdog
  // ========================================================================
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Whole run is a few hundred cycles; 200 us leaves wide margin
  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  // ========================================================================
  // Shared tasks
  // ========================================================================
  // Compare one design value with the modelled value
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, msg, seen, exp);
    end
  endtask
  // One APB transfer; answer taken at the rising edge that sees pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) num_errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait on negedges until the design output matches, bounded
  task automatic wait_se(input logic v, input int lim);
    n = 0;
    while (se_clk_en !== v && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
    if (se_clk_en !== v) num_errors++;
  endtask
  task automatic stop_test();
    if (num_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  // ========================================================================
  initial begin
    {rst, supply_ok, req, pll_lock, psel, penable, pwrite} = 7'b1000000;
    paddr = 8'h00;
    pwdata = 32'h0;
    half = 4'h4;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (20) @(negedge clk_sys);
    // Pin still high: not a request, parts stay idle
    check({se_clk_en, diff_comp_oe_n, vco_en}, {1'b0, 4'hf, 1'b1}, "idle");
    apb(1'b0, CPD_REG_DRIVE_MODE, 32'h0);
    check(rd, 32'h0, "mode reset");
    apb(1'b0, 8'h08, 32'h0);
    check({err, rd}, {1'b1, 32'h0}, "unmapped");
    supply_ok <= 1'b1;
    repeat (40) @(negedge clk_sys);
    check({se_clk_en, diff_true_oe_n}, {1'b0, 4'hf}, "held before lock");
    @(posedge clk_sys);
    pll_lock <= 1'b1;
    wait_se(1'b1, 60);
    check({diff_clk_en, clk_stable}, {4'hf, 1'b1}, "run up");
    apb(1'b0, CPD_REG_STATUS, 32'h0);
    check({rd[8:6], rd[5], rd[0]}, {3'h1, 1'b1, 1'b1}, "role switch");
    // Request dropped between the two qualifying edges
    @(posedge cpu_clock_complement);
    @(posedge clk_sys);
    req <= 1'b1;
    @(posedge cpu_clock_complement);
    repeat (2) @(posedge clk_sys);
    req <= 1'b0;
    repeat (60) @(negedge clk_sys);
    check(se_clk_en, 1'b1, "requal");
    // Full down and up at two complement rates
    for (int f = 0; f < 2; f++) begin
      half <= (f == 0) ? 4'h3 : 4'h6;
      m = $random(seed) & 15;
      apb(1'b1, CPD_REG_DRIVE_MODE, 32'(m));
      apb(1'b0, CPD_REG_DRIVE_MODE, 32'h0);
      check(rd[3:0], m[3:0], "mode rw");
      repeat (20) @(posedge clk_sys);
      req <= 1'b1;
      wait_se(1'b0, 120);
      check({se_clk_en, diff_clk_en, vco_en}, {1'b0, 4'hf, 1'b1}, "se first");
      n = 0;
      while (diff_clk_en !== 4'h0 && n < 200) begin
        @(negedge clk_sys);
        n++;
      end
      check(n <= 8 * (f == 0 ? 3 : 6) + 4, 1'b1, "park late");
      check(diff_true_oe_n, m[3:0], "park oe");
      check(diff_comp_oe_n, 4'hf, "park comp");
      check(diff_true_high & ~m[3:0], ~m[3:0] & 4'hf, "park high");
      check(vco_en, 1'b1, "osc after");
      repeat (3) @(negedge clk_sys);
      check({vco_en, osc_en}, 2'b00, "osc off");
      @(posedge clk_sys);
      pll_lock <= 1'b0;
      repeat (20) @(posedge clk_sys);
      req <= 1'b0;
      n = 0;
      while (vco_en !== 1'b1 && n < 20) begin
        @(negedge clk_sys);
        n++;
      end
      check({diff_true_oe_n, diff_true_high}, 8'h0f, "drive high");
      @(posedge clk_sys);
      pll_lock <= 1'b1;
      wait_se(1'b1, 60);
      check({diff_clk_en, clk_stable}, {4'hf, 1'b1}, "run again");
    end
    stop_test();
  end
endmodule
